//--- logic/awic_map.svh
// Register offsets, field positions, reset values and timing counts of the wake-up block.
// Notes on behaviour
// - Powered device presents x, y, z samples
// - Rate code 7 gives 100 Hz wake rate
// - Duration register counts wake-rate cycles
// - Level register sets threshold, 1/16 g steps
// - Config 38 gives enabled, active-high pulse pin
// - C2 powers up and enables wake engine
// - Wake event sets status, cause bit, pin
// - Axis mask defaults to all directions
// - No bus answer for 30 ms
// - Samples valid only after start-up delay
// - Latch select: held level or short pulse
// - Polarity bit sets active pin level
// - Pin enable gates interrupt onto pin
// - Release read clears causes, flag, latched-mode pin
// - Event only after motion lasts duration
// - Pulse mode drops on return to inactive
// - Six direction masks gate wake events
`ifndef AWIC_MAP_SVH
`define AWIC_MAP_SVH

`define AWIC_CLK_HZ        50000000
`define AWIC_OFS_X_LO      8'h06
`define AWIC_OFS_CAUSE1    8'h16
`define AWIC_OFS_CAUSE2    8'h17
`define AWIC_OFS_STATUS    8'h18
`define AWIC_OFS_RELEASE   8'h1A
`define AWIC_OFS_MAIN      8'h1B
`define AWIC_OFS_RATE      8'h1D
`define AWIC_OFS_PINCFG    8'h1E
`define AWIC_OFS_MASK      8'h1F
`define AWIC_OFS_DURATION  8'h29
`define AWIC_OFS_LEVEL     8'h6A

`define AWIC_BIT_POWER     7
`define AWIC_BIT_RES       6
`define AWIC_BIT_WAKE_EN   1
`define AWIC_BIT_LATCH     3
`define AWIC_BIT_POL       4
`define AWIC_BIT_PIN_EN    5
`define AWIC_BIT_IRQ_FLAG  4
`define AWIC_BIT_WAKE_SRC  1

`define AWIC_RST_MAIN      8'h00
`define AWIC_RST_RATE      8'h00
`define AWIC_RST_PINCFG    8'h00
`define AWIC_RST_MASK      8'h3F
`define AWIC_RST_DURATION  8'h00
`define AWIC_RST_LEVEL     8'h00

`define AWIC_RATE_TOP_CODE 3'h7
`define AWIC_RATE_TOP_HZ   100
`define AWIC_PWRUP_MS      30
`define AWIC_START_LO_MS   2
`define AWIC_START_HI_MS   2
`define AWIC_PULSE_US      50
`define AWIC_LEVEL_SHIFT   6
`define AWIC_TICK_CYC      (`AWIC_CLK_HZ / `AWIC_RATE_TOP_HZ)
`define AWIC_PWRUP_CYC     (`AWIC_PWRUP_MS * (`AWIC_CLK_HZ / 1000))
`define AWIC_START_LO_CYC  (`AWIC_START_LO_MS * (`AWIC_CLK_HZ / 1000))
`define AWIC_START_HI_CYC  (`AWIC_START_HI_MS * (`AWIC_CLK_HZ / 1000))
`define AWIC_PULSE_CYC     (`AWIC_PULSE_US * (`AWIC_CLK_HZ / 1000000))

`endif

//--- logic/awic_pkg.sv
// Types shared by the wake-up interrupt block.
package awic_pkg;
	// Phases of the serial register port.
	typedef enum logic [2:0] {
		SP_IDLE,
		SP_ADDR,
		SP_REG,
		SP_WDATA,
		SP_ACK,
		SP_RDATA,
		SP_MACK
	} awic_phase_e;

	typedef logic [7:0]  awic_byte_t;
	typedef logic [11:0] awic_sample_t;
endpackage : awic_pkg

//--- logic/awic_wakeup_ctrl.sv
// Serial register port, wake-up motion engine and interrupt pin of the accelerometer.
`timescale 1ns/1ps
`include "awic_map.svh"

module awic_wakeup_ctrl #(
	parameter logic [6:0]  DEV_ADDR     = 7'h2A,               // Arbitrary bus address.
	parameter int unsigned PWRUP_CYC    = `AWIC_PWRUP_CYC,     // 30 ms after reset.
	parameter int unsigned START_LO_CYC = `AWIC_START_LO_CYC,  // Start-up at low resolution.
	parameter int unsigned START_HI_CYC = `AWIC_START_HI_CYC,  // Start-up at high resolution.
	parameter int unsigned TICK_CYC     = `AWIC_TICK_CYC       // One cycle of the 100 Hz rate.
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	input  wire awic_pkg::awic_sample_t accel_x,
	input  wire awic_pkg::awic_sample_t accel_y,
	input  wire awic_pkg::awic_sample_t accel_z,
	output logic                        irq_pin
);
	import awic_pkg::*;

	localparam logic [11:0] PULSE_CYC = 12'(`AWIC_PULSE_CYC);  // Pin pulse width in cycles.

	// Two-stage synchronisers and one history stage for edge detection.
	logic [1:0]  scl_sync_q;            // Clock pin synchroniser.
	logic [1:0]  sda_sync_q;            // Data pin synchroniser.
	logic        scl_prev_q;            // Previous synchronised clock level.
	logic        sda_prev_q;            // Previous synchronised data level.
	logic        scl_s;                 // Synchronised clock.
	logic        sda_s;                 // Synchronised data.
	logic        scl_rise;              // Clock rising edge.
	logic        scl_fall;              // Clock falling edge.
	logic        bus_start;             // Start condition.
	logic        bus_stop;              // Stop condition.

	awic_phase_e phase_q;               // Serial port phase.
	awic_phase_e after_ack_q;           // Phase that follows our acknowledge.
	logic [3:0]  bit_q;                 // Bits moved in the current byte.
	awic_byte_t  shift_q;               // Byte shift register.
	awic_byte_t  ptr_q;                 // Register pointer.
	logic        sda_oe_n_q;            // Low while we pull the data line.
	logic        byte_wr;               // A data byte addressed to ptr_q is complete.
	logic        byte_ld;               // A read byte is fetched from ptr_q.
	logic        rel_rd;                // The release register is being read.
	awic_byte_t  rd_byte;               // Read multiplexer output.

	awic_byte_t  main_q;                // main_control.
	awic_byte_t  rate_q;                // wake_rate_control.
	awic_byte_t  pincfg_q;              // irq_pin_config.
	awic_byte_t  mask_q;                // axis_mask_reg.
	awic_byte_t  duration_q;            // motion_duration.
	awic_byte_t  level_q;               // motion_level.

	logic [20:0] pwr_cnt_q;             // Power-up wait counter.
	logic        ready_q;               // Serial port may answer.
	logic [31:0] start_cnt_q;           // Start-up delay counter.
	logic        valid_q;               // Samples are valid.
	awic_sample_t samp_q [3];           // Captured samples, x, y, z.
	awic_sample_t axis_in [3];          // Sample inputs as an array.

	logic [31:0] tick_cnt_q;            // Wake-rate divider.
	logic [31:0] tick_top;              // Divider period for the selected rate.
	logic        tick;                  // One pulse per wake-rate cycle.
	logic [5:0]  dir_hit;               // Directions above the threshold.
	logic [5:0]  dir_live;              // Unmasked directions above the threshold.
	logic        motion;                // Any unmasked direction moving.
	logic        engine_on;             // Engine is powered and enabled.
	logic [7:0]  run_cnt_q;             // Wake-rate cycles of continuous motion.
	logic        active_q;              // Engine is in the active state.
	logic        wake_event;            // Inactive to active transition.
	logic        wake_drop;             // Active to inactive transition.

	logic        irq_flag_q;            // Status interrupt flag.
	logic        wake_src_q;            // Wake source flag.
	logic [5:0]  cause_dir_q;           // Directions that caused the event.
	logic [11:0] pulse_cnt_q;           // Remaining pin pulse cycles.
	logic        pin_assert;            // Pin should show the active level.
	logic        irq_pin_q;             // Registered pin level.

	assign scl_s     = scl_sync_q[1];
	assign sda_s     = sda_sync_q[1];
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// Pins from the host pass two flip-flops; only the second stage is read further.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// The port stays deaf until the power-up time has passed.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwr_cnt_q <= 21'h0;
			ready_q   <= 1'b0;
		end else if (!ready_q) begin
			pwr_cnt_q <= pwr_cnt_q + 21'h1;
			ready_q   <= (pwr_cnt_q >= 21'(PWRUP_CYC - 1));
		end
	end

	// Write and fetch strobes; start and stop abort whatever byte is in flight.
	assign byte_wr = scl_fall & ~bus_start & ~bus_stop & (phase_q == SP_WDATA) & (bit_q == 4'h8);
	assign byte_ld = scl_fall & ~bus_start & ~bus_stop &
		(((phase_q == SP_ACK) & (after_ack_q == SP_RDATA)) | (phase_q == SP_MACK));
	assign rel_rd  = byte_ld & (ptr_q == `AWIC_OFS_RELEASE);

	// Read multiplexer; unmapped addresses and the release register read as zero.
	always_comb begin
		rd_byte = 8'h00;
		case (ptr_q)
			`AWIC_OFS_X_LO:         rd_byte = {samp_q[0][3:0], 4'h0};
			`AWIC_OFS_X_LO + 8'h01: rd_byte = samp_q[0][11:4];
			`AWIC_OFS_X_LO + 8'h02: rd_byte = {samp_q[1][3:0], 4'h0};
			`AWIC_OFS_X_LO + 8'h03: rd_byte = samp_q[1][11:4];
			`AWIC_OFS_X_LO + 8'h04: rd_byte = {samp_q[2][3:0], 4'h0};
			`AWIC_OFS_X_LO + 8'h05: rd_byte = samp_q[2][11:4];
			`AWIC_OFS_CAUSE1:       rd_byte = {6'h00, wake_src_q, 1'b0};
			`AWIC_OFS_CAUSE2:       rd_byte = {2'h0, cause_dir_q};
			`AWIC_OFS_STATUS:       rd_byte = {3'h0, irq_flag_q, 4'h0};
			`AWIC_OFS_MAIN:         rd_byte = main_q;
			`AWIC_OFS_RATE:         rd_byte = rate_q;
			`AWIC_OFS_PINCFG:       rd_byte = pincfg_q;
			`AWIC_OFS_MASK:         rd_byte = mask_q;
			`AWIC_OFS_DURATION:     rd_byte = duration_q;
			`AWIC_OFS_LEVEL:        rd_byte = level_q;
			default:                rd_byte = 8'h00;
		endcase
	end

	// Serial slave: address byte, pointer byte, then data with auto-increment.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q     <= SP_IDLE;
			after_ack_q <= SP_IDLE;
			bit_q       <= 4'h0;
			shift_q     <= 8'h00;
			ptr_q       <= 8'h00;
			sda_oe_n_q  <= 1'b1;
		end else if (bus_start) begin
			phase_q    <= SP_ADDR;
			bit_q      <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (bus_stop) begin
			phase_q    <= SP_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (byte_ld) begin
			// Data changes only while the clock is low, so it is driven on the fall.
			shift_q    <= rd_byte;
			ptr_q      <= ptr_q + 8'h01;
			sda_oe_n_q <= rd_byte[7];
			bit_q      <= 4'h0;
			phase_q    <= SP_RDATA;
		end else begin
			case (phase_q)
				SP_ADDR, SP_REG, SP_WDATA: begin
					if (scl_rise && bit_q != 4'h8) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_q   <= bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						bit_q      <= 4'h0;
						sda_oe_n_q <= 1'b0;
						phase_q    <= SP_ACK;
						if (phase_q == SP_ADDR) begin
							// A foreign address, or one before power-up, is not answered.
							if (shift_q[7:1] != DEV_ADDR || !ready_q) begin
								sda_oe_n_q <= 1'b1;
								phase_q    <= SP_IDLE;
							end
							after_ack_q <= shift_q[0] ? SP_RDATA : SP_REG;
						end else if (phase_q == SP_REG) begin
							ptr_q       <= shift_q;
							after_ack_q <= SP_WDATA;
						end else begin
							ptr_q       <= ptr_q + 8'h01;
							after_ack_q <= SP_WDATA;
						end
					end
				end
				SP_ACK: begin
					if (scl_fall) begin
						sda_oe_n_q <= 1'b1;
						bit_q      <= 4'h0;
						phase_q    <= after_ack_q;
					end
				end
				SP_RDATA: begin
					if (scl_rise) begin
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						sda_oe_n_q <= 1'b1;
						phase_q    <= SP_MACK;
					end else if (scl_fall) begin
						shift_q    <= {shift_q[6:0], 1'b0};
						sda_oe_n_q <= shift_q[6];
					end
				end
				SP_MACK: begin
					// A not-acknowledge ends the read; the host then sends stop.
					if (scl_rise && sda_s) begin
						phase_q <= SP_IDLE;
					end
				end
				default: phase_q <= SP_IDLE;
			endcase
		end
	end

	// Writable registers; the axis mask resets to all directions enabled.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_q     <= `AWIC_RST_MAIN;
			rate_q     <= `AWIC_RST_RATE;
			pincfg_q   <= `AWIC_RST_PINCFG;
			mask_q     <= `AWIC_RST_MASK;
			duration_q <= `AWIC_RST_DURATION;
			level_q    <= `AWIC_RST_LEVEL;
		end else if (byte_wr) begin
			case (ptr_q)
				`AWIC_OFS_MAIN:     main_q     <= shift_q;
				`AWIC_OFS_RATE:     rate_q     <= shift_q;
				`AWIC_OFS_PINCFG:   pincfg_q   <= shift_q;
				`AWIC_OFS_MASK:     mask_q     <= {2'h0, shift_q[5:0]};
				`AWIC_OFS_DURATION: duration_q <= shift_q;
				`AWIC_OFS_LEVEL:    level_q    <= shift_q;
				default:            main_q     <= main_q;
			endcase
		end
	end

	// Start-up delay after power-on; the figure depends on the resolution.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_cnt_q <= 32'h0;
			valid_q     <= 1'b0;
		end else if (!main_q[`AWIC_BIT_POWER]) begin
			start_cnt_q <= 32'h0;
			valid_q     <= 1'b0;
		end else if (!valid_q) begin
			start_cnt_q <= start_cnt_q + 32'h1;
			valid_q     <= main_q[`AWIC_BIT_RES] ? (start_cnt_q >= START_HI_CYC - 1) :
				(start_cnt_q >= START_LO_CYC - 1);
		end
	end

	assign axis_in[0] = accel_x;
	assign axis_in[1] = accel_y;
	assign axis_in[2] = accel_z;

	// Per-axis capture and threshold test; the level counts sixteenths of a g.
	for (genvar i = 0; i < 3; i++) begin : g_axis
		logic signed [14:0] wide;
		logic signed [14:0] limit;
		assign wide  = {{3{axis_in[i][11]}}, axis_in[i]};
		assign limit = $signed({1'b0, level_q, 6'h00});
		assign dir_hit[5 - 2 * i] = (wide < -limit);
		assign dir_hit[4 - 2 * i] = (wide > limit);

		// Samples read as zero until the outputs are valid.
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				samp_q[i] <= 12'h000;
			end else begin
				samp_q[i] <= valid_q ? axis_in[i] : 12'h000;
			end
		end
	end

	assign dir_live  = dir_hit & mask_q[5:0];
	assign motion    = |dir_live;
	assign engine_on = valid_q & main_q[`AWIC_BIT_WAKE_EN];
	// Each code step below the top halves the rate, so the divider doubles.
	assign tick_top  = TICK_CYC << (`AWIC_RATE_TOP_CODE - rate_q[2:0]);
	assign tick      = engine_on & (tick_cnt_q >= tick_top - 32'h1);

	// Wake-rate divider; it restarts whenever the engine is off.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= 32'h0;
		end else if (!engine_on || tick) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end

	// Motion must persist for the programmed number of wake-rate cycles.
	assign wake_event = tick & motion & ~active_q & ({1'b0, run_cnt_q} + 9'h1 >= {1'b0, duration_q});
	assign wake_drop  = (tick & ~motion & active_q) | (~engine_on & active_q);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_cnt_q <= 8'h00;
			active_q  <= 1'b0;
		end else if (!engine_on || (tick && !motion)) begin
			run_cnt_q <= 8'h00;
			active_q  <= 1'b0;
		end else if (tick) begin
			run_cnt_q <= (run_cnt_q == 8'hFF) ? run_cnt_q : run_cnt_q + 8'h01;
			active_q  <= active_q | wake_event;
		end
	end

	// Sticky flags; a new event in the clearing cycle wins over the clear.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_flag_q  <= 1'b0;
			wake_src_q  <= 1'b0;
			cause_dir_q <= 6'h00;
		end else if (wake_event) begin
			irq_flag_q  <= 1'b1;
			wake_src_q  <= 1'b1;
			cause_dir_q <= dir_live;
		end else if (rel_rd || (wake_drop && pincfg_q[`AWIC_BIT_LATCH])) begin
			irq_flag_q  <= 1'b0;
			wake_src_q  <= 1'b0;
			cause_dir_q <= 6'h00;
		end
	end

	// One fixed-width pulse per event in pulse mode.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pulse_cnt_q <= 12'h000;
		end else if (wake_event && pincfg_q[`AWIC_BIT_LATCH]) begin
			pulse_cnt_q <= PULSE_CYC;
		end else if (pulse_cnt_q != 12'h000) begin
			pulse_cnt_q <= pulse_cnt_q - 12'h001;
		end
	end

	// Latched mode shows the flag; pulse mode shows the counter.
	assign pin_assert = pincfg_q[`AWIC_BIT_LATCH] ? (pulse_cnt_q != 12'h000) : irq_flag_q;

	// A disabled pin rests at its idle level, the inverse of the active level.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_pin_q <= 1'b1;
		end else begin
			irq_pin_q <= ~((pin_assert & pincfg_q[`AWIC_BIT_PIN_EN]) ^ pincfg_q[`AWIC_BIT_POL]);
		end
	end

	assign sda_out  = 1'b0;
	assign sda_oe_n = sda_oe_n_q;
	assign irq_pin  = irq_pin_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_no_answer_early:
	assert property (!ready_q |-> sda_oe_n_q) else $error("Data line pulled before power-up time.");

	a_main_write:
	assert property (byte_wr && ptr_q == `AWIC_OFS_MAIN |=> main_q == $past(shift_q))
		else $error("Main control write lost.");

	a_event_flags:
	assert property (wake_event |=> irq_flag_q && wake_src_q) else $error("Wake event flags not set.");

	a_release_clear:
	assert property (rel_rd && !wake_event |=> !irq_flag_q && !wake_src_q && cause_dir_q == 6'h00)
		else $error("Release read did not clear flags.");

	a_pin_gated:
	assert property (!pincfg_q[`AWIC_BIT_PIN_EN] |=> irq_pin_q == !$past(pincfg_q[`AWIC_BIT_POL]))
		else $error("Disabled pin left idle level.");

	a_pin_level:
	assert property (pincfg_q[`AWIC_BIT_PIN_EN] && !pincfg_q[`AWIC_BIT_LATCH] && irq_flag_q ##1
		$stable(pincfg_q) |-> irq_pin_q == pincfg_q[`AWIC_BIT_POL])
		else $error("Latched enabled pin not at active level.");

	a_pulse_start:
	assert property (wake_event && pincfg_q[`AWIC_BIT_LATCH] |=> pulse_cnt_q == PULSE_CYC ##2
		!irq_pin_q == !pincfg_q[`AWIC_BIT_POL] || !pincfg_q[`AWIC_BIT_PIN_EN])
		else $error("Pulse did not start at full width.");

	a_pulse_count:
	assert property (pulse_cnt_q != 12'h000 && !wake_event |=> pulse_cnt_q == $past(pulse_cnt_q) - 12'h001)
		else $error("Pulse counter did not step down.");

	a_persist_gate:
	assert property (wake_event |-> tick && motion && run_cnt_q + 8'h01 >= duration_q)
		else $error("Wake event before motion lasted.");

	a_mask_blocks:
	assert property ((dir_hit & ~mask_q[5:0]) != 6'h00 && (dir_hit & mask_q[5:0]) == 6'h00
		|-> !motion) else $error("Masked direction raised motion.");

	a_unlatch_drop:
	assert property (wake_drop && pincfg_q[`AWIC_BIT_LATCH] && !wake_event |=> !irq_flag_q)
		else $error("Pulse-mode flag kept after inactivity.");

	a_start_delay:
	assert property ($rose(main_q[`AWIC_BIT_POWER]) |-> !valid_q ##1 samp_q[0] == 12'h000)
		else $error("Samples valid without start-up delay.");

	c_wake_event: cover property (wake_event);
	c_release_read: cover property (rel_rd);
	c_reg_write: cover property (byte_wr);
endmodule : awic_wakeup_ctrl

//--- verification/awic_host_model.sv
// Host model that drives the two-wire register port of the wake-up block.
`timescale 1ns/1ps
module awic_host_model #(
	parameter logic [6:0] DEV = 7'h2A // Arbitrary bus address.
) (
	input  wire logic       clk,
	input  wire logic       sda_oe_n,
	output logic            scl,
	output logic            sda,
	output logic            rd_valid,
	output logic [7:0]      rd_data
);
	logic hsda_q; // Host half of the wired-AND data line.
	// The line has a pull-up, so it reads high unless some party pulls it low.
	assign sda = hsda_q & sda_oe_n;
	initial begin
		scl = 1'b1;
		hsda_q = 1'b1;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end
	// A quarter of the 160 ns link period; the clock stands high between frames.
	task automatic q();
		repeat (2) @(posedge clk);
	endtask : q
	// Data moves only in mid low phase, so it never looks like a start or stop.
	task automatic bit_x(input logic b, output logic r);
		q();
		hsda_q <= b;
		q();
		scl <= 1'b1;
		q();
		q();
		r = sda;
		scl <= 1'b0;
	endtask : bit_x
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		q();
		hsda_q <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		hsda_q <= 1'b0;
		q();
		scl <= 1'b0;
	endtask : start
	// Stop: data rises while the clock is high, then the bus is left free.
	task automatic stop();
		q();
		hsda_q <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		hsda_q <= 1'b1;
		q();
	endtask : stop
	// Eight bits, most significant first, then the acknowledge slot.
	task automatic byte_x(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ab, ack);
	endtask : byte_x
	// Pointer then one data byte; ok is set only if all three bytes were acknowledged.
	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
		logic [7:0] j;
		logic [2:0] a;
		start();
		byte_x({DEV, 1'b0}, 1'b1, j, a[2]);
		byte_x(ofs, 1'b1, j, a[1]);
		byte_x(dat, 1'b1, j, a[0]);
		stop();
		ok = (a === 3'b000);
	endtask : write_reg
	// Pointer, repeated start, one byte closed by a not-acknowledge; result strobed out.
	task automatic read_reg(input logic [7:0] ofs);
		logic [7:0] j;
		logic       a;
		start();
		byte_x({DEV, 1'b0}, 1'b1, j, a);
		byte_x(ofs, 1'b1, j, a);
		start();
		byte_x({DEV, 1'b1}, 1'b1, j, a);
		byte_x(8'hFF, 1'b1, rd_data, a);
		stop();
		rd_valid <= 1'b1;
		@(posedge clk);
		rd_valid <= 1'b0;
	endtask : read_reg
endmodule : awic_host_model

//--- verification/awic_wakeup_ctrl_tb_top.sv
// Self-checking bench of the wake-up interrupt block.
`timescale 1ns/1ps
module awic_wakeup_ctrl_tb_top;
	import awic_pkg::*;
	localparam int         T = 40; // Shortened wake-rate tick.
	localparam logic [7:0] OFS[6] = '{8'h1B, 8'h1D, 8'h1E, 8'h1F, 8'h29, 8'h6A};
	localparam logic [7:0] RST[6] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
	logic         clk = 1'b0;
	logic         reset_n = 1'b0;
	logic         scl, sda, sda_out, sda_oe_n, irq_pin, rd_valid, ok;
	logic [7:0]   rd_data, v;
	logic [7:0]   exp_q[$]; // Expected read bytes, oldest first.
	awic_sample_t ax = '0, ay = '0, az = '0;
	int           fails = 0;
	int           num_checks = 0;
	int           n;
	always #10 clk = ~clk;
	// The power-up wait outlasts the first address byte, so that byte is refused.
	awic_wakeup_ctrl #(.PWRUP_CYC(150), .START_LO_CYC(20), .START_HI_CYC(20), .TICK_CYC(T))
		i_awic_wakeup_ctrl (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .accel_x(ax), .accel_y(ay), .accel_z(az),
		.irq_pin(irq_pin));
	awic_host_model i_awic_host_model (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda),
		.rd_valid(rd_valid), .rd_data(rd_data));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	// Each read result is matched against the oldest note.
	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			check(rd_data, exp_q.pop_front());
		end
	end
	// Cuts a hang short; the whole sequence needs far fewer cycles.
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		finish_test();
	end
	task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
		i_awic_host_model.write_reg(ofs, dat, ok);
		check(ok, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		exp_q.push_back(exp);
		i_awic_host_model.read_reg(ofs);
	endtask : rd
	// Counts cycles until the pin shows a level, giving up at the limit.
	// No bus traffic is issued while the pin is awaited.
	task automatic wait_pin(input logic lvl, input int lim);
		n = 0;
		while (irq_pin !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_pin
	initial begin
		void'($urandom(4));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		check(irq_pin, 1'b1);
		check(sda_out, 1'b0);
		i_awic_host_model.write_reg(8'h1B, 8'hC0, ok);
		check(ok, 1'b0);
		for (int i = 0; i < 6; i++) begin
			rd(OFS[i], RST[i]);
		end
		for (int i = 0; i < 6; i++) begin
			// The wake engine stays off here, so no stray event outlives this test.
			v = 8'($urandom) & ((i == 0) ? 8'hFD : 8'hFF);
			wr(OFS[i], v);
			rd(OFS[i], (i == 3) ? {2'h0, v[5:0]} : v);
		end
		rd(8'h50, 8'h00);
		$display("Register test done");
		ax <= 12'($urandom);
		wr(8'h1B, 8'hC0);
		rd(8'h07, ax[11:4]);
		rd(8'h06, {ax[3:0], 4'h0});
		$display("Sample test done");
		ax <= 12'h100;
		wr(8'h1D, 8'h07);
		wr(8'h29, 8'h0A);
		wr(8'h6A, 8'h04);
		wr(8'h1F, 8'h3F);
		wr(8'h1E, 8'h38);
		wr(8'h1B, 8'hC2);
		wait_pin(1'b1, 15 * T);
		check(irq_pin, 1'b0);
		ax <= 12'h101;
		wait_pin(1'b1, 12 * T);
		check(8'(n >= 9 * T && n <= 11 * T), 8'h01);
		wait_pin(1'b0, 3000);
		check(8'(n == 2500), 8'h01);
		rd(8'h18, 8'h10);
		rd(8'h16, 8'h02);
		rd(8'h17, 8'h10);
		rd(8'h1A, 8'h00);
		rd(8'h18, 8'h00);
		check(irq_pin, 1'b0);
		$display("Pulse test done");
		ax <= '0;
		wr(8'h1E, 8'h20);
		check(irq_pin, 1'b1);
		wr(8'h1F, 8'h37);
		ay <= 12'hED4;
		wait_pin(1'b0, 15 * T);
		check(irq_pin, 1'b1);
		wr(8'h1F, 8'h3F);
		wait_pin(1'b0, 12 * T);
		ay <= '0;
		repeat (5 * T) @(posedge clk);
		check(irq_pin, 1'b0);
		rd(8'h17, 8'h08);
		rd(8'h1A, 8'h00);
		check(irq_pin, 1'b1);
		rd(8'h16, 8'h00);
		$display("Latched test done");
		wr(8'h1E, 8'h10);
		az <= 12'h200;
		wait_pin(1'b1, 12 * T);
		check(irq_pin, 1'b0);
		rd(8'h18, 8'h10);
		$display("Disabled pin test done");
		repeat (4) @(posedge clk);
		finish_test();
	end
endmodule : awic_wakeup_ctrl_tb_top
